//--- mbd_pkg.sv
/*
 * Constants, types and decode helpers for the Manchester byte decoder.
 * Assumes one system clock and a synchronous active-low reset.
 */
// How it works
// - Setting the start bit begins decoding of the two loaded bytes.
// - A finished decode sets the ready flag for software.
// - A byte holding pair 00 or 11 sets the error flag.
// - Invalid input forces the decoded byte to all ones.
// - Four pairs per byte, first pair on top; 01 gives 1, 10 gives 0.
// - Decoding is the exact inverse of encoding, so data round-trips unchanged.
package mbd_pkg;

    localparam int MBD_BYTE_W = 8;
    localparam int MBD_NIB_W = 4;
    localparam int MBD_IN_COUNT = 2;
    localparam int MBD_HIGH_IDX = 1;
    localparam int MBD_LOW_IDX = 0;

    // Code words for one bit pair
    localparam logic [1:0] MBD_PAIR_ONE = 2'h1;
    localparam logic [1:0] MBD_PAIR_ZERO = 2'h2;

    // Output forced on invalid input
    localparam logic [7:0] MBD_ALL_ONES = 8'hFF;

    // Values after reset
    localparam logic [7:0] MBD_BYTE_RST = 8'h00;
    localparam logic MBD_FLAG_RST = 1'b0;

    // Cycles from the edge that takes a start to the first edge that samples the result
    localparam int MBD_DECODE_CYCLES = 2;

    typedef enum logic [1:0] {
        MBD_IDLE = 2'h1,
        MBD_DECODE = 2'h2
    } mbd_state_t;

    // One decoded byte: its nibble and whether the code word was bad
    typedef struct packed {
        logic bad;
        logic [3:0] nibble;
    } mbd_nib_t;

    // Status seen by software
    typedef struct packed {
        logic busy;
        logic ready;
        logic error;
        logic [7:0] decoded;
    } mbd_status_t;

    // True when every pair of the byte is 01 or 10
    function automatic logic mbd_code_valid(input logic [7:0] code);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < MBD_NIB_W; i++) begin
            if (code[2*i +: 2] != MBD_PAIR_ONE && code[2*i +: 2] != MBD_PAIR_ZERO) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : mbd_code_valid

    // Pair i lands on nibble bit i, so the first pair is the top bit
    function automatic logic [3:0] mbd_nibble(input logic [7:0] code);
        logic [3:0] nib;
        nib = 4'h0;
        for (int i = 0; i < MBD_NIB_W; i++) begin
            nib[i] = (code[2*i +: 2] == MBD_PAIR_ONE);
        end
        return nib;
    endfunction : mbd_nibble

endpackage : mbd_pkg

//--- mbd_byte_decoder.sv
/*
 * Decodes one Manchester byte into a nibble and a bad-code mark.
 * Assumes the byte is stable while its result is used; purely combinational.
 */
`timescale 1ns/1ps

module mbd_byte_decoder (
    input wire logic [7:0] codeByte,
    output mbd_pkg::mbd_nib_t decoded
);
    import mbd_pkg::*;

    // Pair check and bit recovery
    always_comb begin
        decoded.bad = !mbd_code_valid(codeByte);
        decoded.nibble = mbd_nibble(codeByte);
    end

endmodule : mbd_byte_decoder

//--- mbd_decoder.sv
/*
 * Manchester byte decoder: two encoded input bytes, a start strobe,
 * one decoded byte with ready and error flags.
 * Assumes all control inputs come from logic on sys_clk, so none is
 * synchronised; strobes are one-cycle pulses.
 */
`timescale 1ns/1ps

module mbd_decoder (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic highWrite,
    input wire logic [7:0] highData,
    input wire logic lowWrite,
    input wire logic [7:0] lowData,
    input wire logic decodeStart,
    input wire logic readyClear,
    input wire logic errorClear,
    output logic [7:0] encodedInputHigh,
    output logic [7:0] encodedInputLow,
    output mbd_pkg::mbd_status_t status
);
    import mbd_pkg::*;

    mbd_state_t state_reg;
    mbd_state_t state_next;
    logic [7:0] high_reg;
    logic [7:0] low_reg;
    logic [7:0] decoded_reg;
    logic ready_reg;
    logic error_reg;
    logic busy_reg;
    logic startTaken;
    logic finishing;
    logic anyBad;
    logic [7:0] inBytes [MBD_IN_COUNT];
    mbd_nib_t nibs [MBD_IN_COUNT];
    logic [7:0] joined;

    // Start is honoured only while idle
    assign startTaken = decodeStart && (state_reg == MBD_IDLE);
    assign finishing = (state_reg == MBD_DECODE);

    // Encoded input registers, frozen while a decode runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            high_reg <= MBD_BYTE_RST;
        end else if (highWrite && state_reg == MBD_IDLE) begin
            high_reg <= highData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            low_reg <= MBD_BYTE_RST;
        end else if (lowWrite && state_reg == MBD_IDLE) begin
            low_reg <= lowData;
        end
    end

    // One decoder per input byte
    assign inBytes[MBD_HIGH_IDX] = high_reg;
    assign inBytes[MBD_LOW_IDX] = low_reg;

    for (genvar g = 0; g < MBD_IN_COUNT; g++) begin : g_byte
        mbd_byte_decoder u_dec (
            .codeByte(inBytes[g]),
            .decoded(nibs[g])
        );
    end

    // Upper nibble from the high byte, lower from the low byte
    assign joined = {nibs[MBD_HIGH_IDX].nibble, nibs[MBD_LOW_IDX].nibble};
    assign anyBad = nibs[MBD_HIGH_IDX].bad || nibs[MBD_LOW_IDX].bad;

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MBD_IDLE: begin
                if (startTaken) begin
                    state_next = MBD_DECODE;
                end
            end
            MBD_DECODE: begin
                state_next = MBD_IDLE;
            end
            default: begin
                state_next = MBD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= MBD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy from the start until the result is shown
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_reg <= MBD_FLAG_RST;
        end else begin
            busy_reg <= (state_next == MBD_DECODE);
        end
    end

    // Decoded byte, all ones on bad code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            decoded_reg <= MBD_BYTE_RST;
        end else if (finishing) begin
            decoded_reg <= anyBad ? MBD_ALL_ONES : joined;
        end
    end

    // Ready flag: completion sets, start or software clears, set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ready_reg <= MBD_FLAG_RST;
        end else if (finishing) begin
            ready_reg <= 1'b1;
        end else if (startTaken || readyClear) begin
            ready_reg <= 1'b0;
        end
    end

    // Error flag: a bad decode sets, start, software or a good decode clears, set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            error_reg <= MBD_FLAG_RST;
        end else if (finishing && anyBad) begin
            error_reg <= 1'b1;
        end else if (startTaken || errorClear || finishing) begin
            error_reg <= 1'b0;
        end
    end

    // Outputs, all from flip-flops
    assign encodedInputHigh = high_reg;
    assign encodedInputLow = low_reg;
    assign status.busy = busy_reg;
    assign status.ready = ready_reg;
    assign status.error = error_reg;
    assign status.decoded = decoded_reg;

    // Checks on the decode sequence
    sequence s_launch;
        decodeStart && (state_reg == MBD_IDLE) ##1 busy_reg;
    endsequence

    sequence s_finish_good;
        finishing && !anyBad;
    endsequence

    sequence s_finish_bad;
        finishing && anyBad;
    endsequence

    a_start_launches: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (decodeStart && state_reg == MBD_IDLE) |=> busy_reg && state_reg == MBD_DECODE)
        else $error("start in idle did not launch a decode");

    a_ready_after_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_launch |=> ready_reg && !busy_reg)
        else $error("ready not set two edges after start");

    a_ready_not_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (decodeStart && state_reg == MBD_IDLE) |=> !ready_reg)
        else $error("ready stood while decode was running");

    a_error_on_bad: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_finish_bad |=> error_reg && ready_reg)
        else $error("bad code word did not set error");

    a_error_code_tie: assert property (@(posedge sys_clk) disable iff (!rst_n)
        finishing |-> anyBad == (|({high_reg[7], high_reg[5], high_reg[3], high_reg[1]}
            ~^ {high_reg[6], high_reg[4], high_reg[2], high_reg[0]})
            || |({low_reg[7], low_reg[5], low_reg[3], low_reg[1]}
            ~^ {low_reg[6], low_reg[4], low_reg[2], low_reg[0]})))
        else $error("bad mark disagrees with pair check");

    a_ones_on_bad: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_finish_bad |=> decoded_reg == 8'hFF)
        else $error("decoded byte not all ones on bad input");

    a_good_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_finish_good |=> !error_reg && decoded_reg[0] == $past(low_reg[1:0] == 2'h1)
            && decoded_reg[7] == $past(high_reg[7:6] == 2'h1))
        else $error("pair to bit mapping wrong");

    a_round_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (finishing && low_reg == 8'hA5 && high_reg == 8'h55) |=> decoded_reg == 8'hF3)
        else $error("known code pair did not decode to its data");

    a_nibble_halves: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_finish_good |=> decoded_reg[7:4]
            == $past({high_reg[6], high_reg[4], high_reg[2], high_reg[0]})
            && decoded_reg[3:0] == $past({low_reg[6], low_reg[4], low_reg[2], low_reg[0]}))
        else $error("nibbles landed in the wrong halves");

    a_inputs_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_reg |=> $stable(high_reg) && $stable(low_reg))
        else $error("input bytes changed during decode");

    // Checks on refusals, clears and writes
    a_start_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (decodeStart && state_reg == MBD_DECODE) |=> !busy_reg && state_reg == MBD_IDLE)
        else $error("start during a decode was not ignored");

    a_busy_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busy_reg |=> !busy_reg && ready_reg)
        else $error("busy stood longer than one cycle");

    a_ready_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (readyClear && !finishing) |=> !ready_reg)
        else $error("ready survived its clear");

    a_error_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (errorClear && !(finishing && anyBad)) |=> !error_reg)
        else $error("error survived its clear");

    a_high_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (highWrite && state_reg == MBD_IDLE) |=> high_reg == $past(highData))
        else $error("high input byte not loaded");

    a_low_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (lowWrite && state_reg == MBD_IDLE) |=> low_reg == $past(lowData))
        else $error("low input byte not loaded");

endmodule : mbd_decoder

//--- mbd_decoder_test.sv
/*
 * Self-checking bench for the Manchester byte decoder.
 * Assumes the decoder's plain strobe ports and a 4 ns system clock.
 */
`timescale 1ns/1ps

module mbd_decoder_test;
    import mbd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic highWrite = 1'b0;
    logic [7:0] highData = 8'h00;
    logic lowWrite = 1'b0;
    logic [7:0] lowData = 8'h00;
    logic decodeStart = 1'b0;
    logic readyClear = 1'b0;
    logic errorClear = 1'b0;
    logic [7:0] encodedInputHigh;
    logic [7:0] encodedInputLow;
    mbd_status_t status;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] badCode [4] = '{8'h00, 8'hFF, 8'h54, 8'hD5};

    // Clock, 4 ns period
    always #2 sys_clk = ~sys_clk;

    mbd_decoder DUT (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .highWrite(highWrite),
        .highData(highData),
        .lowWrite(lowWrite),
        .lowData(lowData),
        .decodeStart(decodeStart),
        .readyClear(readyClear),
        .errorClear(errorClear),
        .encodedInputHigh(encodedInputHigh),
        .encodedInputLow(encodedInputLow),
        .status(status)
    );

    // Encodes a nibble: data 1 gives pair 01, data 0 pair 10, top bit first
    function automatic logic [7:0] enc(input logic [3:0] nib);
        logic [7:0] c;
        for (int i = 0; i < 4; i++) begin
            c[2*i +: 2] = nib[i] ? 2'h1 : 2'h2;
        end
        return c;
    endfunction : enc

    // Prints the counts and the verdict, then stops
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // Loads both encoded bytes in one cycle
    task load(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge sys_clk);
        highWrite <= 1'b1;
        highData <= hi;
        lowWrite <= 1'b1;
        lowData <= lo;
        @(posedge sys_clk);
        highWrite <= 1'b0;
        lowWrite <= 1'b0;
    endtask : load

    // Pulses start; with tryWr it also holds start and writes while busy; waits for ready
    task decode(input logic [7:0] junk, input logic tryWr);
        int n;
        logic [1:0] midFlags;
        n = 0;
        decodeStart <= 1'b1;
        @(posedge sys_clk);
        decodeStart <= tryWr;
        highWrite <= tryWr;
        highData <= junk;
        @(negedge sys_clk);
        midFlags = {status.busy, status.ready};
        @(posedge sys_clk);
        decodeStart <= 1'b0;
        highWrite <= 1'b0;
        @(negedge sys_clk);
        // Bounded wait, so a missing ready cannot hang the run
        while (status.ready !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        chk({9'h0, midFlags}, 11'h2, "busy during decode");
        chk({9'h0, n == 0, status.busy}, 11'h2, "ready in time");
    endtask : decode

    // Strobes one clear input for a cycle
    task clr(input logic isErr);
        @(posedge sys_clk);
        errorClear <= isErr;
        readyClear <= !isErr;
        @(posedge sys_clk);
        errorClear <= 1'b0;
        readyClear <= 1'b0;
        @(negedge sys_clk);
    endtask : clr

    // Watchdog well beyond the expected run of about 1100 cycles
    initial begin
        #80000;
        err_total++;
        conclude;
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(status, 11'h0, "status after reset");
        chk({3'h0, encodedInputHigh}, 11'h0, "high after reset");
        chk({3'h0, encodedInputLow}, 11'h0, "low after reset");
        // Every data byte survives an encode and decode
        for (int d = 0; d < 256; d++) begin
            load(enc(d[7:4]), enc(d[3:0]));
            decode(8'h00, 1'b0);
            chk(status, {3'b010, d[7:0]}, "round trip");
        end
        // Bad pairs in either byte flag an error and give all ones
        for (int i = 0; i < 4; i++) begin
            load(badCode[i], 8'h55);
            decode(8'h00, 1'b0);
            chk(status, {3'b011, 8'hFF}, "bad high byte");
            load(8'h55, badCode[i]);
            decode(8'h00, 1'b0);
            chk(status, {3'b011, 8'hFF}, "bad low byte");
        end
        clr(1'b1);
        chk(status, {3'b010, 8'hFF}, "error cleared");
        clr(1'b0);
        chk(status, {3'b000, 8'hFF}, "ready cleared");
        load(8'h00, 8'hA5);
        decode(8'h00, 1'b0);
        chk(status, {3'b011, 8'hFF}, "bad before good");
        load(8'h55, 8'hA5);
        decode(8'h00, 1'b0);
        chk(status, {3'b010, 8'hF3}, "good after bad");
        // A write and a second start while busy are ignored
        load(8'hA9, 8'h6A);
        decode(8'h55, 1'b1);
        chk(status, {3'b010, 8'h18}, "write while busy");
        chk({3'h0, encodedInputHigh}, {3'h0, 8'hA9}, "high kept");
        chk({3'h0, encodedInputLow}, {3'h0, 8'h6A}, "low kept");
        // A write with the start strobe is decoded
        @(posedge sys_clk);
        highWrite <= 1'b1;
        highData <= 8'h96;
        decode(8'h00, 1'b0);
        chk(status, {3'b010, 8'h68}, "write with start");
        conclude;
    end

endmodule : mbd_decoder_test
